/* core/msb_pkg.sv */
// Addresses, field positions, layouts and reset values of the upper SFR bank
package msb_pkg;
	// Register addresses in the SFR space
	localparam logic [7:0] ADR_PORT0_PINS = 8'h80;
	localparam logic [7:0] ADR_STACK_POINTER = 8'h81;
	localparam logic [7:0] ADR_PORT0_OUT_CFG_A = 8'h84;
	localparam logic [7:0] ADR_PORT0_OUT_CFG_B = 8'h85;
	localparam logic [7:0] ADR_KEYPAD_MASK = 8'h86;
	localparam logic [7:0] ADR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] ADR_TIMER_RUN_CONTROL = 8'h88;
	localparam logic [7:0] ADR_TIMER_MODE_SELECT = 8'h89;
	localparam logic [7:0] ADR_TIMER0_LOW_BYTE = 8'h8a;
	localparam logic [7:0] ADR_TIMER1_LOW_BYTE = 8'h8b;
	localparam logic [7:0] ADR_TIMER0_HIGH_BYTE = 8'h8c;
	localparam logic [7:0] ADR_TIMER1_HIGH_BYTE = 8'h8d;
	localparam logic [7:0] ADR_TIMER_AUX_MODE = 8'h8f;
	localparam logic [7:0] ADR_PORT1_PINS = 8'h90;
	localparam logic [7:0] ADR_PORT1_OUT_CFG_A = 8'h91;
	localparam logic [7:0] ADR_PORT1_OUT_CFG_B = 8'h92;
	localparam logic [7:0] ADR_KEYPAD_MATCH_PATTERN = 8'h93;
	localparam logic [7:0] ADR_KEYPAD_CONTROL = 8'h94;
	localparam logic [7:0] ADR_RC_OSC_TUNING = 8'h96;
	localparam logic [7:0] ADR_WATCHDOG_CONTROL = 8'ha7;
	localparam logic [7:0] ADR_POWER_CONTROL_AUX = 8'hb5;
	localparam logic [7:0] ADR_POWER_CONTROL_RESERVED = 8'hb6;
	localparam logic [7:0] ADR_IRQ_PRIORITY0_UPPER = 8'hb7;
	localparam logic [7:0] ADR_IRQ_PRIORITY0_LOWER = 8'hb8;
	localparam logic [7:0] ADR_WATCHDOG_RELOAD = 8'hc1;
	localparam logic [7:0] ADR_WATCHDOG_SERVICE_FIRST = 8'hc2;
	localparam logic [7:0] ADR_WATCHDOG_SERVICE_SECOND = 8'hc3;
	localparam logic [7:0] ADR_PROGRAM_STATUS = 8'hd0;
	localparam logic [7:0] ADR_RTC_CONTROL = 8'hd1;
	localparam logic [7:0] ADR_RTC_COUNT_HIGH = 8'hd2;
	localparam logic [7:0] ADR_RTC_COUNT_LOW = 8'hd3;
	localparam logic [7:0] ADR_RESET_CAUSE = 8'hdf;
	localparam logic [7:0] ADR_IRQ_ENABLE_SECOND = 8'he8;
	localparam logic [7:0] ADR_PORT0_INPUT_DISABLE = 8'hf6;
	localparam logic [7:0] ADR_IRQ_PRIORITY1_UPPER = 8'hf7;
	localparam logic [7:0] ADR_IRQ_PRIORITY1_LOWER = 8'hf8;
	// Non-zero reset values and the reset-cause mask
	localparam logic [7:0] RST_PORT_LATCH = 8'hff;
	localparam logic [7:0] RST_STACK_POINTER = 8'h07;
	localparam logic [7:0] RST_OUT_CFG_A = 8'hff;
	localparam logic [7:0] RST_KEYPAD_PATTERN = 8'hff;
	localparam logic [7:0] RST_WATCHDOG_CONTROL = 8'he5;
	localparam logic [7:0] RST_WATCHDOG_RELOAD = 8'hff;
	localparam logic [7:0] RST_RTC_CONTROL = 8'h60;
	localparam logic [7:0] RST_CAUSE_POR = 8'h30;
	localparam logic [7:0] MASK_RESET_CAUSE = 8'h37;
	// Field positions and the trim load cycle
	localparam int BIT_TIMER1_OVERFLOW = 7;
	localparam int BIT_TIMER0_OVERFLOW = 5;
	localparam int BIT_KEYPAD_FLAG = 0;
	localparam int BIT_WD_TIMEOUT_FLAG = 1;
	localparam int BIT_BROWNOUT_FLAG = 5;
	localparam int BIT_WATCHDOG_RESET_FLAG = 2;
	localparam int BIT_SOFTWARE_RESET_FLAG = 1;
	localparam int BIT_EXTERNAL_RESET_FLAG = 0;
	localparam logic [1:0] TRIM_LOAD_CYCLE = 2'h2;

	// Implemented bit positions of each register
	function automatic logic [7:0] impl_mask(input logic [7:0] a);
		case (a)
			ADR_PORT0_PINS, ADR_PORT0_OUT_CFG_A, ADR_PORT0_OUT_CFG_B: impl_mask = 8'hbe;
			ADR_KEYPAD_MASK, ADR_KEYPAD_MATCH_PATTERN: impl_mask = 8'h0c;
			ADR_TIMER_RUN_CONTROL: impl_mask = 8'hf0;
			ADR_TIMER_MODE_SELECT: impl_mask = 8'h33;
			ADR_TIMER_AUX_MODE: impl_mask = 8'h11;
			ADR_PORT1_PINS: impl_mask = 8'h24;
			ADR_PORT1_OUT_CFG_A, ADR_PORT1_OUT_CFG_B: impl_mask = 8'h04;
			ADR_KEYPAD_CONTROL: impl_mask = 8'h03;
			ADR_WATCHDOG_CONTROL: impl_mask = 8'he7;
			ADR_POWER_CONTROL_AUX: impl_mask = 8'hb0;
			ADR_IRQ_PRIORITY0_UPPER, ADR_IRQ_PRIORITY0_LOWER: impl_mask = 8'h6a;
			ADR_RTC_CONTROL: impl_mask = 8'he3;
			ADR_RESET_CAUSE: impl_mask = MASK_RESET_CAUSE;
			ADR_IRQ_ENABLE_SECOND, ADR_IRQ_PRIORITY1_UPPER,
			ADR_IRQ_PRIORITY1_LOWER: impl_mask = 8'h86;
			ADR_PORT0_INPUT_DISABLE: impl_mask = 8'h3e;
			ADR_POWER_CONTROL: impl_mask = 8'h3f;
			ADR_STACK_POINTER, ADR_TIMER0_LOW_BYTE,
			ADR_TIMER1_LOW_BYTE, ADR_TIMER0_HIGH_BYTE, ADR_TIMER1_HIGH_BYTE,
			ADR_RC_OSC_TUNING, ADR_WATCHDOG_RELOAD, ADR_WATCHDOG_SERVICE_FIRST,
			ADR_WATCHDOG_SERVICE_SECOND, ADR_PROGRAM_STATUS, ADR_RTC_COUNT_HIGH,
			ADR_RTC_COUNT_LOW: impl_mask = 8'hff;
			default: impl_mask = 8'h00;
		endcase
	endfunction
endpackage

/* core/msb_reset_cause.sv */
// Reset-cause flag register with set-wins software update
module msb_reset_cause
(
	// Clock and power-on reset
	input wire logic clk,
	input wire logic rst_n,
	// Reset source events
	input wire logic wdt_reset_evt,
	input wire logic sw_reset_evt,
	input wire logic ext_reset_evt,
	input wire logic brownout_evt,
	// Software write
	input wire logic cause_wr,
	input wire logic [7:0] cause_wdata,
	// Flags
	output logic [7:0] cause_r
);
	logic [7:0] set_bits;

	always_comb
	begin
		set_bits = 8'h00;
		set_bits[msb_pkg::BIT_WATCHDOG_RESET_FLAG] = wdt_reset_evt;
		set_bits[msb_pkg::BIT_SOFTWARE_RESET_FLAG] = sw_reset_evt;
		set_bits[msb_pkg::BIT_EXTERNAL_RESET_FLAG] = ext_reset_evt;
		set_bits[msb_pkg::BIT_BROWNOUT_FLAG] = brownout_evt;
	end

	// A new reset event outranks a software clear in the same cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cause_r <= msb_pkg::RST_CAUSE_POR;
		else if (cause_wr)
			cause_r <= (cause_wdata & msb_pkg::MASK_RESET_CAUSE) | set_bits;
		else
			cause_r <= cause_r | set_bits;
	end
endmodule

/* core/msb_sfr_bank.sv */
// Upper special-function register bank with power-on and warm reset handling
module msb_sfr_bank
(
	// Clock and power-on reset
	input wire logic clk,
	input wire logic rst_n,
	// CPU SFR access
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic sfr_bit_wr,
	input wire logic [2:0] sfr_bit_sel,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Warm reset sources, one-cycle pulses
	input wire logic wdt_reset_evt,
	input wire logic sw_reset_evt,
	input wire logic ext_reset_evt,
	input wire logic brownout_evt,
	// Hardware flag events
	input wire logic timer0_overflow_set,
	input wire logic timer1_overflow_set,
	input wire logic keypad_flag_set,
	// Pins and factory trim
	input wire logic [7:0] port0_pin_in,
	input wire logic [7:0] port1_pin_in,
	input wire logic [7:0] factory_trim,
	// Port drivers
	output logic [7:0] port0_out,
	output logic [7:0] port0_oe,
	output logic [7:0] port1_out,
	output logic [7:0] port1_oe,
	// Control towards other blocks
	output logic [7:0] osc_tuning,
	output logic [7:0] watchdog_control,
	output logic [7:0] power_control_aux
);
	logic [7:0] regs_r [256];
	logic [7:0] p0_meta_r;
	logic [7:0] p0_sync_r;
	logic [7:0] p1_meta_r;
	logic [7:0] p1_sync_r;
	logic [7:0] trim_meta_r;
	logic [7:0] trim_sync_r;
	logic [1:0] por_cnt_r;
	logic [7:0] rdata_r;
	logic [7:0] p0_out_r;
	logic [7:0] p0_oe_r;
	logic [7:0] p1_out_r;
	logic [7:0] p1_oe_r;
	logic [7:0] reset_cause;
	logic warm_any;
	logic bit_ok;
	logic wr_hit;
	logic cause_wr;
	logic [7:0] bit_one;
	logic [7:0] wr_val;
	logic [7:0] rd_val;

	// Reset value of each register
	function automatic logic [7:0] reset_val(input logic [7:0] a);
		case (a)
			msb_pkg::ADR_PORT0_PINS, msb_pkg::ADR_PORT1_PINS: reset_val = msb_pkg::RST_PORT_LATCH;
			msb_pkg::ADR_STACK_POINTER: reset_val = msb_pkg::RST_STACK_POINTER;
			msb_pkg::ADR_PORT0_OUT_CFG_A, msb_pkg::ADR_PORT1_OUT_CFG_A: reset_val = msb_pkg::RST_OUT_CFG_A;
			msb_pkg::ADR_KEYPAD_MATCH_PATTERN: reset_val = msb_pkg::RST_KEYPAD_PATTERN;
			msb_pkg::ADR_WATCHDOG_CONTROL: reset_val = msb_pkg::RST_WATCHDOG_CONTROL;
			msb_pkg::ADR_WATCHDOG_RELOAD: reset_val = msb_pkg::RST_WATCHDOG_RELOAD;
			msb_pkg::ADR_RTC_CONTROL: reset_val = msb_pkg::RST_RTC_CONTROL;
			default: reset_val = 8'h00;
		endcase
		reset_val = reset_val & msb_pkg::impl_mask(a);
	endfunction

	// Registers that only power-on reset touches
	function automatic logic por_only(input logic [7:0] a);
		case (a)
			msb_pkg::ADR_RTC_CONTROL, msb_pkg::ADR_RTC_COUNT_HIGH, msb_pkg::ADR_RTC_COUNT_LOW,
			msb_pkg::ADR_RC_OSC_TUNING, msb_pkg::ADR_WATCHDOG_CONTROL: por_only = 1'b1;
			default: por_only = 1'b0;
		endcase
	endfunction

	// Bit addressable registers sit on addresses ending in 0 or 8
	function automatic logic bit_addressable(input logic [7:0] a);
		bit_addressable = (a[2:0] == 3'h0) && (msb_pkg::impl_mask(a) != 8'h00);
	endfunction

	// Pin and trim synchronisers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			p0_meta_r <= 8'h00;
			p0_sync_r <= 8'h00;
			p1_meta_r <= 8'h00;
			p1_sync_r <= 8'h00;
			trim_meta_r <= 8'h00;
			trim_sync_r <= 8'h00;
		end
		else
		begin
			p0_meta_r <= port0_pin_in;
			p0_sync_r <= p0_meta_r;
			p1_meta_r <= port1_pin_in;
			p1_sync_r <= p1_meta_r;
			trim_meta_r <= factory_trim;
			trim_sync_r <= trim_meta_r;
		end
	end

	// Counts edges after power-on release until the trim is loaded
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			por_cnt_r <= 2'h0;
		else if (por_cnt_r != 2'h3)
			por_cnt_r <= por_cnt_r + 2'h1;
	end

	always_comb
	begin
		warm_any = wdt_reset_evt | sw_reset_evt | ext_reset_evt | brownout_evt;
		bit_ok = bit_addressable(sfr_addr);
		bit_one = 8'(8'h01 << sfr_bit_sel);
		wr_hit = !warm_any && (sfr_wr || (sfr_bit_wr && bit_ok));
		cause_wr = wr_hit && (sfr_addr == msb_pkg::ADR_RESET_CAUSE);
		if (sfr_bit_wr)
			wr_val = (regs_r[sfr_addr] & ~bit_one) | (sfr_wdata[0] ? bit_one : 8'h00);
		else
			wr_val = sfr_wdata;
	end

	// Register array; warm resets leave the power-on-only group alone except the watchdog timeout flag, which a watchdog reset sets
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 256; i++)
				regs_r[i] <= reset_val(8'(i));
		end
		else
		begin
			if (warm_any)
			begin
				for (int i = 0; i < 256; i++)
					if (!por_only(8'(i)))
						regs_r[i] <= reset_val(8'(i));
			end
			else if (wr_hit)
				regs_r[sfr_addr] <= wr_val & msb_pkg::impl_mask(sfr_addr);
			if (por_cnt_r == msb_pkg::TRIM_LOAD_CYCLE)
				regs_r[msb_pkg::ADR_RC_OSC_TUNING] <= trim_sync_r;
			if (wdt_reset_evt)
				regs_r[msb_pkg::ADR_WATCHDOG_CONTROL][msb_pkg::BIT_WD_TIMEOUT_FLAG] <= 1'b1;
			if (timer1_overflow_set && !warm_any)
				regs_r[msb_pkg::ADR_TIMER_RUN_CONTROL][msb_pkg::BIT_TIMER1_OVERFLOW] <= 1'b1;
			if (timer0_overflow_set && !warm_any)
				regs_r[msb_pkg::ADR_TIMER_RUN_CONTROL][msb_pkg::BIT_TIMER0_OVERFLOW] <= 1'b1;
			if (keypad_flag_set && !warm_any)
				regs_r[msb_pkg::ADR_KEYPAD_CONTROL][msb_pkg::BIT_KEYPAD_FLAG] <= 1'b1;
		end
	end

	msb_reset_cause u_cause
	(
		.clk(clk),
		.rst_n(rst_n),
		.wdt_reset_evt(wdt_reset_evt),
		.sw_reset_evt(sw_reset_evt),
		.ext_reset_evt(ext_reset_evt),
		.brownout_evt(brownout_evt),
		.cause_wr(cause_wr),
		.cause_wdata(wr_val),
		.cause_r(reset_cause)
	);

	// Port registers read the pins, not the latches
	always_comb
	begin
		case (sfr_addr)
			msb_pkg::ADR_PORT0_PINS: rd_val = p0_sync_r;
			msb_pkg::ADR_PORT1_PINS: rd_val = p1_sync_r;
			msb_pkg::ADR_RESET_CAUSE: rd_val = reset_cause;
			msb_pkg::ADR_WATCHDOG_SERVICE_FIRST, msb_pkg::ADR_WATCHDOG_SERVICE_SECOND: rd_val = 8'h00;
			default: rd_val = regs_r[sfr_addr];
		endcase
	end

	// Unused bit positions read as zero, which software must not rely on
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_r <= 8'h00;
		else if (sfr_rd)
			rdata_r <= rd_val & msb_pkg::impl_mask(sfr_addr);
	end

	// Driver enabled on implemented pins unless the pin is in input-only mode (A=1, B=0)
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			p0_out_r <= 8'h00;
			p0_oe_r <= 8'h00;
			p1_out_r <= 8'h00;
			p1_oe_r <= 8'h00;
		end
		else
		begin
			p0_out_r <= regs_r[msb_pkg::ADR_PORT0_PINS];
			p0_oe_r <= ~(regs_r[msb_pkg::ADR_PORT0_OUT_CFG_A] & ~regs_r[msb_pkg::ADR_PORT0_OUT_CFG_B])
				& msb_pkg::impl_mask(msb_pkg::ADR_PORT0_OUT_CFG_A);
			p1_out_r <= regs_r[msb_pkg::ADR_PORT1_PINS];
			p1_oe_r <= ~(regs_r[msb_pkg::ADR_PORT1_OUT_CFG_A] & ~regs_r[msb_pkg::ADR_PORT1_OUT_CFG_B])
				& msb_pkg::impl_mask(msb_pkg::ADR_PORT1_OUT_CFG_A);
		end
	end

	assign sfr_rdata = rdata_r;
	assign port0_out = p0_out_r;
	assign port0_oe = p0_oe_r;
	assign port1_out = p1_out_r;
	assign port1_oe = p1_oe_r;
	assign osc_tuning = regs_r[msb_pkg::ADR_RC_OSC_TUNING];
	assign watchdog_control = regs_r[msb_pkg::ADR_WATCHDOG_CONTROL];
	assign power_control_aux = regs_r[msb_pkg::ADR_POWER_CONTROL_AUX];

	a_unimpl_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
		sfr_rd && sfr_addr == msb_pkg::ADR_KEYPAD_MASK |=> (sfr_rdata & 8'hf3) == 8'h00)
		else $error("keypad mask read shows unimplemented bits");
	a_input_only_oe: assert property (@(posedge clk) disable iff (!rst_n)
		regs_r[msb_pkg::ADR_PORT0_OUT_CFG_A] == 8'hbe && regs_r[msb_pkg::ADR_PORT0_OUT_CFG_B] == 8'h00
		|=> port0_oe == 8'h00)
		else $error("port 0 drives while input-only");
	a_por_cause_value: assert property (@(posedge clk) disable iff (!rst_n)
		por_cnt_r == 2'h0 |-> reset_cause == 8'h30)
		else $error("reset cause wrong after power-on");
	a_rtc_keeps_warm: assert property (@(posedge clk) disable iff (!rst_n)
		warm_any |=> regs_r[msb_pkg::ADR_RTC_COUNT_HIGH] == $past(regs_r[msb_pkg::ADR_RTC_COUNT_HIGH])
		&& regs_r[msb_pkg::ADR_RTC_CONTROL] == $past(regs_r[msb_pkg::ADR_RTC_CONTROL]))
		else $error("warm reset disturbed RTC registers");
	a_trim_load_once: assert property (@(posedge clk) disable iff (!rst_n)
		por_cnt_r == 2'h2 |=> osc_tuning == $past(trim_sync_r) ##1 por_cnt_r == 2'h3)
		else $error("factory trim not loaded");
	a_watchdog_control_por_value: assert property (@(posedge clk) disable iff (!rst_n)
		por_cnt_r == 2'h0 |-> watchdog_control == 8'he5)
		else $error("watchdog control reset value wrong");
	a_wd_timeout_set: assert property (@(posedge clk) disable iff (!rst_n)
		wdt_reset_evt |=> watchdog_control[1] && reset_cause[2])
		else $error("watchdog reset not recorded");
	a_warm_port_cfg: assert property (@(posedge clk) disable iff (!rst_n)
		sw_reset_evt |=> regs_r[msb_pkg::ADR_PORT0_OUT_CFG_A] == 8'hbe
		&& regs_r[msb_pkg::ADR_PORT0_OUT_CFG_B] == 8'h00 && regs_r[msb_pkg::ADR_KEYPAD_MASK] == 8'h00)
		else $error("warm reset left port or keypad config");
	a_overflow_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
		timer0_overflow_set && !warm_any |=> regs_r[msb_pkg::ADR_TIMER_RUN_CONTROL][5])
		else $error("timer 0 overflow lost");
	a_bit_write_local: assert property (@(posedge clk) disable iff (!rst_n)
		sfr_bit_wr && !sfr_wr && !warm_any && sfr_addr == msb_pkg::ADR_PROGRAM_STATUS
		|=> ((regs_r[msb_pkg::ADR_PROGRAM_STATUS] ^ $past(regs_r[msb_pkg::ADR_PROGRAM_STATUS]))
		& ~$past(bit_one)) == 8'h00)
		else $error("bit write disturbed other bits");

	// Field layouts: stored bits never leave the implemented positions
	a_keypad_mask_bits: assert property (@(posedge clk) disable iff (!rst_n)
		(regs_r[msb_pkg::ADR_KEYPAD_MASK] & 8'hf3) == 8'h00)
		else $error("keypad mask holds bits outside 3 and 2");
	a_prio0_fields: assert property (@(posedge clk) disable iff (!rst_n)
		(regs_r[msb_pkg::ADR_IRQ_PRIORITY0_UPPER] & 8'h95) == 8'h00)
		else $error("priority 0 high register holds unused bits");
	a_prio1_fields: assert property (@(posedge clk) disable iff (!rst_n)
		(regs_r[msb_pkg::ADR_IRQ_PRIORITY1_UPPER] & 8'h79) == 8'h00)
		else $error("priority 1 high register holds unused bits");
	a_pwr_aux_fields: assert property (@(posedge clk) disable iff (!rst_n)
		(power_control_aux & 8'h4f) == 8'h00)
		else $error("aux power control holds unused bits");
	a_timer_aux_fields: assert property (@(posedge clk) disable iff (!rst_n)
		(regs_r[msb_pkg::ADR_TIMER_AUX_MODE] & 8'hee) == 8'h00)
		else $error("timer aux mode holds unused bits");
	a_timer_run_control_fields: assert property (@(posedge clk) disable iff (!rst_n)
		(regs_r[msb_pkg::ADR_TIMER_RUN_CONTROL] & 8'h0f) == 8'h00)
		else $error("timer control holds unused bits");
	a_input_dis_fields: assert property (@(posedge clk) disable iff (!rst_n)
		(regs_r[msb_pkg::ADR_PORT0_INPUT_DISABLE] & 8'hc1) == 8'h00)
		else $error("input disable holds unused bits");
	a_trim_write_full: assert property (@(posedge clk) disable iff (!rst_n)
		sfr_wr && !sfr_bit_wr && !warm_any && sfr_addr == msb_pkg::ADR_RC_OSC_TUNING
		&& por_cnt_r != msb_pkg::TRIM_LOAD_CYCLE |=> osc_tuning == $past(sfr_wdata))
		else $error("oscillator tuning write lost bits");

	// Power-on-only group and reset-source bookkeeping
	a_rtc_count_por: assert property (@(posedge clk) disable iff (!rst_n)
		por_cnt_r == 2'h0 |-> regs_r[msb_pkg::ADR_RTC_COUNT_HIGH] == 8'h00
		&& regs_r[msb_pkg::ADR_RTC_COUNT_LOW] == 8'h00)
		else $error("RTC count not cleared by power-on");
	a_watchdog_control_kept_warm: assert property (@(posedge clk) disable iff (!rst_n)
		warm_any && !wdt_reset_evt |=> watchdog_control == $past(watchdog_control))
		else $error("warm reset changed watchdog control");
	a_trim_kept_warm: assert property (@(posedge clk) disable iff (!rst_n)
		warm_any && por_cnt_r == 2'h3 |=> osc_tuning == $past(osc_tuning))
		else $error("warm reset changed oscillator tuning");
	a_port_por_input: assert property (@(posedge clk) disable iff (!rst_n)
		por_cnt_r <= 2'h1 |-> port0_oe == 8'h00 && port1_oe == 8'h00)
		else $error("port driver on after power-on");
	a_warm_port_input: assert property (@(posedge clk) disable iff (!rst_n)
		warm_any |=> ##1 port0_oe == 8'h00 && port1_oe == 8'h00)
		else $error("port driver on after warm reset");
	a_warm_clears_prio: assert property (@(posedge clk) disable iff (!rst_n)
		warm_any |=> regs_r[msb_pkg::ADR_IRQ_PRIORITY0_UPPER] == 8'h00
		&& regs_r[msb_pkg::ADR_IRQ_PRIORITY1_UPPER] == 8'h00)
		else $error("warm reset left priority bits");
	a_brownout_recorded: assert property (@(posedge clk) disable iff (!rst_n)
		brownout_evt |=> reset_cause[msb_pkg::BIT_BROWNOUT_FLAG])
		else $error("brownout reset not recorded");
	a_ext_recorded: assert property (@(posedge clk) disable iff (!rst_n)
		ext_reset_evt |=> reset_cause[msb_pkg::BIT_EXTERNAL_RESET_FLAG])
		else $error("external reset not recorded");
	a_bit_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
		sfr_bit_wr && !sfr_wr && !bit_ok && !warm_any && sfr_addr == msb_pkg::ADR_TIMER_MODE_SELECT
		|=> regs_r[msb_pkg::ADR_TIMER_MODE_SELECT] == $past(regs_r[msb_pkg::ADR_TIMER_MODE_SELECT]))
		else $error("bit write changed a byte-only register");

	c_warm_wdt: cover property (@(posedge clk) disable iff (!rst_n) wdt_reset_evt);
	c_bit_write: cover property (@(posedge clk) disable iff (!rst_n) sfr_bit_wr && bit_ok);
	c_trim_load: cover property (@(posedge clk) disable iff (!rst_n) por_cnt_r == 2'h2);
	c_flag_clear_race: cover property (@(posedge clk) disable iff (!rst_n)
		timer1_overflow_set && wr_hit && sfr_addr == msb_pkg::ADR_TIMER_RUN_CONTROL);
	c_pin_read: cover property (@(posedge clk) disable iff (!rst_n)
		sfr_rd && sfr_addr == msb_pkg::ADR_PORT0_PINS);
endmodule

/* verification/mcu_sfr_bank_upper_half_tb_top.sv */
// Self-checking bench for the upper SFR bank
module mcu_sfr_bank_upper_half_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] TRIM_VAL = 8'ha6;
	localparam logic [7:0] FLD_ADR [7] = '{8'h86, 8'hb7, 8'hf7, 8'hb5, 8'h8f, 8'hf6, 8'h96};
	localparam logic [7:0] FLD_MSK [7] = '{8'h0c, 8'h6a, 8'h86, 8'hb0, 8'h11, 8'h3e, 8'hff};
	// Warm sources in bench order: watchdog, software, external, brownout
	localparam logic [7:0] CAUSE_BIT [4] = '{8'h04, 8'h02, 8'h01, 8'h20};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] evt = 4'h0;
	logic t0_set = 1'b0;
	logic t1_set = 1'b0;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_val;
	logic sfr_wr, sfr_rd, sfr_bit_wr;
	logic [2:0] sfr_bit_sel;
	logic [7:0] port0_out, port0_oe, port1_out, port1_oe, osc_tuning, wd_ctl, pwr_aux;
	int num_errors = 0;
	int n_checks = 0;

	always #12.5 clk = ~clk;

	msb_cpu_model cpu_u (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_bit_wr(sfr_bit_wr),
		.sfr_bit_sel(sfr_bit_sel), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

	msb_sfr_bank dut_u (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.wdt_reset_evt(evt[0]), .sw_reset_evt(evt[1]), .ext_reset_evt(evt[2]), .brownout_evt(evt[3]),
		.timer0_overflow_set(t0_set), .timer1_overflow_set(t1_set), .keypad_flag_set(1'b0),
		.port0_pin_in(8'h5a), .port1_pin_in(8'h24), .factory_trim(TRIM_VAL), .port0_out(port0_out),
		.port0_oe(port0_oe), .port1_out(port1_out), .port1_oe(port1_oe), .osc_tuning(osc_tuning),
		.watchdog_control(wd_ctl), .power_control_aux(pwr_aux));

	task automatic summarize();
		$display("Checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		cpu_u.rd(a, rd_val);
		check($sformatf("reg %h", a), exp, rd_val);
	endtask

	// Trim is loaded a few edges after release, so wait before any check
	task automatic por();
		rst_n = 1'b0;
		repeat (16) @(posedge clk);
		#2 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		#2;
	endtask

	task automatic pulse(input int i);
		@(posedge clk);
		#2 evt[i] = 1'b1;
		@(posedge clk);
		#2 evt[i] = 1'b0;
	endtask

	task automatic test_por_values();
		check("port0_oe", 8'h00, port0_oe);
		check("port1_oe", 8'h00, port1_oe);
		check("osc_tuning", TRIM_VAL, osc_tuning);
		check("watchdog_control", 8'he5, wd_ctl);
		check("power_control_aux", 8'h00, pwr_aux);
		check("port0_out", 8'hbe, port0_out);
		check("port1_out", 8'h24, port1_out);
		rd_chk(8'h80, 8'h1a);
		rd_chk(8'h90, 8'h24);
		rd_chk(8'hdf, 8'h30);
		rd_chk(8'ha7, 8'he5);
		rd_chk(8'hd2, 8'h00);
		rd_chk(8'hd3, 8'h00);
		rd_chk(8'h86, 8'h00);
		rd_chk(8'h84, 8'hbe);
		rd_chk(8'h85, 8'h00);
		rd_chk(8'hb7, 8'h00);
		rd_chk(8'hf7, 8'h00);
		rd_chk(8'hb5, 8'h00);
		rd_chk(8'h8f, 8'h00);
		rd_chk(8'h88, 8'h00);
		rd_chk(8'hf6, 8'h00);
		rd_chk(8'h96, TRIM_VAL);
	endtask

	// Ones into every position: only the documented fields may come back
	task automatic test_fields();
		for (int i = 0; i < 7; i++)
		begin
			cpu_u.wr(FLD_ADR[i], 8'hff);
			rd_chk(FLD_ADR[i], FLD_MSK[i]);
		end
		check("power_control_aux", 8'hb0, pwr_aux);
		for (int i = 0; i < 6; i++)
			cpu_u.wr(FLD_ADR[i], 8'h00);
	endtask

	task automatic test_bit_access();
		logic [7:0] acc;
		acc = 8'h00;
		cpu_u.wr(8'h88, 8'h00);
		for (int i = 4; i < 8; i++)
		begin
			acc[i] = 1'b1;
			cpu_u.bwr(8'h88, i[2:0], 1'b1);
			rd_chk(8'h88, acc);
		end
		cpu_u.bwr(8'h88, 3'h5, 1'b0);
		rd_chk(8'h88, 8'hd0);
		cpu_u.wr(8'h88, 8'h00);
		@(posedge clk);
		#2 t0_set = 1'b1;
		@(posedge clk);
		#2 t0_set = 1'b0;
		rd_chk(8'h88, 8'h20);
		// Overflow set and a clearing write in the same cycle: the set must win
		fork
			cpu_u.wr(8'h88, 8'h00);
			begin
				@(posedge clk);
				#2 t1_set = 1'b1;
				@(posedge clk);
				#2 t1_set = 1'b0;
			end
		join
		rd_chk(8'h88, 8'h80);
		cpu_u.wr(8'hd0, 8'ha5);
		cpu_u.bwr(8'hd0, 3'h3, 1'b1);
		rd_chk(8'hd0, 8'had);
		cpu_u.wr(8'h89, 8'h00);
		cpu_u.bwr(8'h89, 3'h0, 1'b1);
		rd_chk(8'h89, 8'h00);
	endtask

	// Software, external, brownout first so the watchdog flag is seen untouched before it is set
	task automatic test_warm_resets();
		int i;
		cpu_u.wr(8'h96, 8'h55);
		cpu_u.wr(8'hd2, 8'h12);
		cpu_u.wr(8'hd3, 8'h34);
		cpu_u.wr(8'ha7, 8'h00);
		cpu_u.wr(8'hb7, 8'h5a);
		cpu_u.wr(8'h84, 8'h00);
		@(posedge clk);
		#2;
		check("port0_oe driven", 8'hbe, port0_oe);
		for (int j = 0; j < 4; j++)
		begin
			i = (j + 1) % 4;
			pulse(i);
			rd_chk(8'ha7, (i == 0) ? 8'h02 : 8'h00);
			rd_chk(8'hd2, 8'h12);
			rd_chk(8'hd3, 8'h34);
			rd_chk(8'h96, 8'h55);
			rd_chk(8'hb7, 8'h00);
			check("port0_oe", 8'h00, port0_oe);
			cpu_u.rd(8'hdf, rd_val);
			check("cause bit", CAUSE_BIT[i], rd_val & CAUSE_BIT[i]);
		end
		por();
		rd_chk(8'ha7, 8'he5);
		rd_chk(8'hd2, 8'h00);
		rd_chk(8'hd3, 8'h00);
		rd_chk(8'hdf, 8'h30);
		check("osc_tuning", TRIM_VAL, osc_tuning);
	endtask

	initial
	begin
		#2ms;
		num_errors++;
		$display("Error run time expected end seen timeout");
		summarize();
	end

	initial
	begin
		por();
		test_por_values();
		test_fields();
		test_bit_access();
		test_warm_resets();
		summarize();
	end
endmodule

/* verification/msb_cpu_model.sv */
// CPU-side model issuing SFR byte writes, bit writes and reads
module msb_cpu_model
(
	// Clock
	input wire logic clk,
	// SFR access
	output logic [7:0] sfr_addr,
	output logic sfr_wr,
	output logic sfr_rd,
	output logic sfr_bit_wr,
	output logic [2:0] sfr_bit_sel,
	output logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_bit_wr = 1'b0;
		sfr_bit_sel = 3'h0;
		sfr_wdata = 8'h00;
	end

	// Idle bus shows the inverted address and, after a write, the inverted data; idle after a read inverts the data the bus already holds
	task automatic idle(input logic [7:0] a, input logic [7:0] d);
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_bit_wr = 1'b0;
		sfr_addr = ~a;
		sfr_wdata = ~d;
		sfr_bit_sel = ~sfr_bit_sel;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#2;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clk);
		#2;
		idle(a, d);
	endtask

	task automatic bwr(input logic [7:0] a, input logic [2:0] sel, input logic v);
		@(posedge clk);
		#2;
		sfr_addr = a;
		sfr_bit_sel = sel;
		sfr_wdata = {7'h00, v};
		sfr_bit_wr = 1'b1;
		@(posedge clk);
		#2;
		idle(a, {7'h00, v});
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#2;
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge clk);
		#2;
		idle(a, sfr_wdata);
		d = sfr_rdata;
	endtask
endmodule
